// ==== hw/glmc_top.v ====
// Purpose: Serial register port and loop mode control of a genlock clock generator
// Assumes: scl/sda sampled as synchronous inputs; SCL low and high each span >= 2 clocks
// Notes:   Open-drain data line split into input, output and output enable
`timescale 1ns/1ps
`default_nettype none
`include "glmc_defines.vh"

module glmc_top #(
  parameter REF_TIMEOUT_CYCLES = `GLMC_REF_TIMEOUT_CYCLES,
  parameter VCXO_CYCLES        = `GLMC_VCXO_CYCLES
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // Serial port
  input  wire        port_enable_n_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  // Mode and reference inputs
  input  wire        genlock_pin_i,
  input  wire        hsync_i,
  input  wire        pll_locked_i,
  input  wire        frame_start_pulse_i,
  // Loop control outputs
  output reg  [1:0]  loop_state_o,
  output reg         freerun_bias_switch_o,
  output reg         loop_filter_output_en_o,
  output reg         phase_detect_en_o,
  output reg         ref_port_select_o,
  output reg         frame_align_o,
  // Status flags
  output reg         reference_loss_o,
  output reg         no_lock_o,
  // Output clock configuration
  output reg  [1:0]  hd_rate_select_o,
  output reg         hd_output_tristate_o,
  output reg         hd_counter_reset_o,
  output reg         hd_clock_valid_o,
  output reg  [15:0] feedback_divider_o,
  output reg  [11:0] frame_pulse_reset_value_o,
  output reg  [15:0] reference_filter_mode_o,
  output reg         output_align_enable_o
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_AACK = 3'h2;
  localparam [2:0] S_WDAT = 3'h3;
  localparam [2:0] S_WACK = 3'h4;
  localparam [2:0] S_RDAT = 3'h5;
  localparam [2:0] S_RACK = 3'h6;
  localparam [7:0] HOLD_MAX = VCXO_CYCLES[7:0];
  // Register bytes
  reg [7:0] mode_r;
  reg [7:0] fb_lo_r;
  reg [7:0] fb_hi_r;
  reg [7:0] hdclk_r;
  reg [7:0] tof_lo_r;
  reg [7:0] tof_hi_r;
  reg [7:0] lpfm_lo_r;
  reg [7:0] lpfm_hi_r;
  // Serial engine
  reg       scl_q_r;
  reg       sda_q_r;
  reg [2:0] st_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [3:0] ptr_r;
  reg       rw_r;
  reg       ptr_pending_r;
  reg       ack_phase_r;
  // Mode control
  reg [1:0] loop_nxt;
  reg [7:0] hold_cnt_r;
  reg       seq_armed_r;
  wire       ref_loss;
  wire       lock_lost;
  wire [7:0] byte_in   = {shift_r[6:0], sda_i};
  wire       scl_rise  = scl_i & ~scl_q_r;
  wire       scl_fall  = ~scl_i & scl_q_r;
  wire       start_det = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire       stop_det  = scl_i & scl_q_r & ~sda_q_r & sda_i;
  wire [1:0] hd_rate   = hdclk_r[`GLMC_HD_RATE_LSB+1:`GLMC_HD_RATE_LSB];
  wire       hd_tri    = hdclk_r[`GLMC_HD_TRI_BIT];
  wire       align_en  = tof_hi_r[`GLMC_TOF_ALIGN_BIT];
  wire       hd_148_35 = (hd_rate == `GLMC_HD_RATE_148_35) & ~hd_tri;
  wire [15:0] fb_val   = {fb_hi_r, fb_lo_r};
  wire [11:0] tof_val  = {tof_hi_r[3:0], tof_lo_r};
  wire [15:0] lpfm_val = {lpfm_hi_r, lpfm_lo_r};

  // Mode from register bit or pin
  wire genlock_on = mode_r[`GLMC_MODE_SRC_BIT] ? mode_r[`GLMC_MODE_LOCK_BIT]
                                               : genlock_pin_i;

  glmc_ref_monitor #(
    .TIMEOUT_CYCLES (REF_TIMEOUT_CYCLES),
    .CNT_W          (16)
  ) u_ref_mon (
    .clk_i            (clk_i),
    .reset_i          (reset_i),
    .hsync_i          (hsync_i),
    .pll_locked_i     (pll_locked_i),
    .reference_loss_o (ref_loss),
    .no_lock_o        (lock_lost)
  );

  // Register read mux; unmapped bytes read zero
  function [7:0] reg_read;
    input [3:0] addr;
    begin
      case (addr)
        `GLMC_REG_MODE:     reg_read = mode_r;
        `GLMC_REG_STATUS:   reg_read = {4'h0, no_lock_o, reference_loss_o, loop_state_o};
        `GLMC_REG_FBDIV_LO: reg_read = fb_lo_r;
        `GLMC_REG_FBDIV_HI: reg_read = fb_hi_r;
        `GLMC_REG_HDCLK:    reg_read = hdclk_r;
        `GLMC_REG_TOF_LO:   reg_read = tof_lo_r;
        `GLMC_REG_TOF_HI:   reg_read = tof_hi_r;
        `GLMC_REG_LPFM_LO:  reg_read = lpfm_lo_r;
        `GLMC_REG_LPFM_HI:  reg_read = lpfm_hi_r;
        default:            reg_read = 8'h00;
      endcase
    end
  endfunction

  // Serial slave and register writes
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q_r       <= 1'b1;
      sda_q_r       <= 1'b1;
      st_r          <= S_IDLE;
      bit_cnt_r     <= 3'h0;
      shift_r       <= 8'h00;
      ptr_r         <= 4'h0;
      rw_r          <= 1'b0;
      ptr_pending_r <= 1'b0;
      ack_phase_r   <= 1'b0;
      sda_o         <= 1'b0;
      sda_oe_o      <= 1'b0;
      mode_r        <= `GLMC_MODE_RESET;
      fb_lo_r       <= 8'h00;
      fb_hi_r       <= 8'h00;
      hdclk_r       <= `GLMC_HDCLK_RESET;
      tof_lo_r      <= 8'h00;
      tof_hi_r      <= 8'h00;
      lpfm_lo_r     <= 8'h00;
      lpfm_hi_r     <= 8'h00;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      sda_o   <= 1'b0;
      if (port_enable_n_i || stop_det) begin
        st_r     <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_det) begin
        st_r        <= S_ADDR;
        bit_cnt_r   <= 3'h0;
        ack_phase_r <= 1'b0;
        sda_oe_o    <= 1'b0;
      end else begin
        case (st_r)
          S_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              shift_r   <= byte_in;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                if (byte_in == `GLMC_ADDR_WRITE) begin
                  rw_r          <= 1'b0;
                  ptr_pending_r <= 1'b1;
                  st_r          <= S_AACK;
                end else if (byte_in == `GLMC_ADDR_READ) begin
                  rw_r <= 1'b1;
                  st_r <= S_AACK;
                end else begin
                  st_r <= S_IDLE;
                end
              end
            end
          end
          S_AACK, S_WACK: begin
            if (scl_fall) begin
              if (!ack_phase_r) begin
                ack_phase_r <= 1'b1;
                sda_oe_o    <= 1'b1;
              end else begin
                ack_phase_r <= 1'b0;
                bit_cnt_r   <= 3'h0;
                if (rw_r) begin
                  shift_r  <= reg_read(ptr_r);
                  sda_oe_o <= ~|(reg_read(ptr_r) & 8'h80);
                  st_r     <= S_RDAT;
                end else begin
                  sda_oe_o <= 1'b0;
                  st_r     <= S_WDAT;
                end
              end
            end
          end
          S_WDAT: begin
            if (scl_rise) begin
              shift_r   <= byte_in;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                st_r <= S_WACK;
                if (ptr_pending_r) begin
                  ptr_pending_r <= 1'b0;
                  ptr_r         <= byte_in[3:0];
                end else begin
                  ptr_r <= ptr_r + 4'h1;
                  case (ptr_r)
                    `GLMC_REG_MODE:     mode_r    <= {4'h0, byte_in[3:0]};
                    `GLMC_REG_FBDIV_LO: fb_lo_r   <= byte_in;
                    `GLMC_REG_FBDIV_HI: fb_hi_r   <= byte_in;
                    `GLMC_REG_HDCLK:    hdclk_r   <= {2'h0, byte_in[5:3], 3'h0};
                    `GLMC_REG_TOF_LO:   tof_lo_r  <= byte_in;
                    `GLMC_REG_TOF_HI:   tof_hi_r  <= {byte_in[7], 3'h0, byte_in[3:0]};
                    `GLMC_REG_LPFM_LO:  lpfm_lo_r <= byte_in;
                    `GLMC_REG_LPFM_HI:  lpfm_hi_r <= byte_in;
                    default:            ptr_r     <= ptr_r + 4'h1;
                  endcase
                end
              end
            end
          end
          S_RDAT: begin
            if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                sda_oe_o <= 1'b0;
                st_r     <= S_RACK;
              end else begin
                shift_r  <= {shift_r[6:0], 1'b0};
                sda_oe_o <= ~shift_r[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              if (sda_i) begin
                st_r <= S_IDLE;
              end else begin
                ptr_r       <= ptr_r + 4'h1;
                ack_phase_r <= 1'b1;
                st_r        <= S_AACK;
              end
            end
          end
          default: begin
            st_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Loop state selection
  always @* begin
    if (!genlock_on) begin
      loop_nxt = `GLMC_LS_FREE;
    end else if (ref_loss) begin
      loop_nxt = mode_r[`GLMC_MODE_HOLD_BIT] ? `GLMC_LS_HOLD
                                             : `GLMC_LS_LOR_FREE;
    end else begin
      loop_nxt = `GLMC_LS_TRACK;
    end
  end

  // Loop control outputs and start-up sequence tracking
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      loop_state_o              <= `GLMC_LS_FREE;
      freerun_bias_switch_o     <= 1'b1;
      loop_filter_output_en_o   <= 1'b1;
      phase_detect_en_o         <= 1'b0;
      ref_port_select_o         <= 1'b0;
      frame_align_o             <= 1'b0;
      reference_loss_o          <= 1'b1;
      no_lock_o                 <= 1'b1;
      hd_rate_select_o          <= 2'h0;
      hd_output_tristate_o      <= 1'b1;
      hd_counter_reset_o        <= 1'b0;
      hd_clock_valid_o          <= 1'b0;
      feedback_divider_o        <= 16'h0000;
      frame_pulse_reset_value_o <= 12'h000;
      reference_filter_mode_o   <= 16'h0000;
      output_align_enable_o     <= 1'b0;
      hold_cnt_r                <= 8'h00;
      seq_armed_r               <= 1'b0;
    end else begin
      loop_state_o <= loop_nxt;
      freerun_bias_switch_o <= (loop_nxt == `GLMC_LS_FREE) |
                               (loop_nxt == `GLMC_LS_LOR_FREE);
      // Drive released in the same edge the loss flag moves the state
      loop_filter_output_en_o <= (loop_nxt != `GLMC_LS_HOLD);
      phase_detect_en_o       <= (loop_nxt == `GLMC_LS_TRACK);
      ref_port_select_o       <= mode_r[`GLMC_MODE_PORT_BIT];
      reference_loss_o        <= ref_loss;
      no_lock_o               <= lock_lost;
      // Output frame is the trigger, so reference and output formats may differ
      frame_align_o <= align_en & frame_start_pulse_i & (loop_state_o == `GLMC_LS_TRACK) &
                       ~lock_lost;
      hd_rate_select_o          <= hd_rate;
      hd_output_tristate_o      <= hd_tri;
      feedback_divider_o        <= fb_val;
      frame_pulse_reset_value_o <= tof_val;
      reference_filter_mode_o   <= lpfm_val;
      output_align_enable_o     <= align_en;
      // Counters of the 148.35 MHz synthesiser held in reset while the set-up is active
      hd_counter_reset_o <= hd_148_35 & align_en & (fb_val == 16'h0001) &
                            (tof_val == 12'h001) & (lpfm_val == 16'h0001);
      if (hd_counter_reset_o) begin
        seq_armed_r <= 1'b0;
        if (hold_cnt_r < HOLD_MAX) begin
          hold_cnt_r <= hold_cnt_r + 8'h01;
        end else begin
          seq_armed_r <= 1'b1;
        end
      end else if (!hd_148_35) begin
        hold_cnt_r       <= 8'h00;
        seq_armed_r      <= 1'b0;
        hd_clock_valid_o <= 1'b0;
      end else if (seq_armed_r && !align_en) begin
        hold_cnt_r       <= 8'h00;
        seq_armed_r      <= 1'b0;
        hd_clock_valid_o <= 1'b1;
      end else if (!align_en) begin
        hold_cnt_r <= 8'h00;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hw/glmc_defines.vh ====
// Purpose: Constants for the genlock mode control block
// Assumes: 40 MHz system clock, byte-wide register space behind the serial port
// Notes:   Contract
// Contract
// - Serial-port enable pin must be low; when high the device never acknowledges.
// - Device answers address byte DCh for writes and DDh for reads.
// - HD 148.35 MHz output is untrusted until its counters are reset by the sequence.
// - Reset gives free run; genlock bit in register 00h selects genlock.
// - Align enable held set re-aligns output phase on every output frame.
// - Mode source bit cleared means mode comes from the genlock pin.
// - Free run ignores the reference; outputs follow the VCXO.
// - Free run closes the switch from bias input to loop filter output.
// - Genlock locks to selected sync; alignment allowed once lock is stable.
// - Outputs may frame-lock to a reference of a different format.
// - Genlock tries to lock regardless of input stability.
// - Genlock, holdover bit 0: reference loss gives free run until reference returns.
// - Genlock, holdover bit 1: reference loss gives holdover until reference returns.
// - Returning reference ends free run or holdover at once, locking resumes.
// - Free run mode ignores reference; loss-induced free run ends on detection.
// - Holdover puts loop filter drive in high impedance when loss flag rises.
// - Reference-loss and unlocked flags report in real time.
`ifndef GLMC_DEFINES_VH
`define GLMC_DEFINES_VH

// Serial address bytes
`define GLMC_ADDR_WRITE     8'hdc
`define GLMC_ADDR_READ      8'hdd

// Register byte addresses
`define GLMC_REG_MODE       4'h0
`define GLMC_REG_STATUS     4'h1
`define GLMC_REG_FBDIV_LO   4'h4
`define GLMC_REG_FBDIV_HI   4'h5
`define GLMC_REG_HDCLK      4'h8
`define GLMC_REG_TOF_LO     4'h9
`define GLMC_REG_TOF_HI     4'ha
`define GLMC_REG_LPFM_LO    4'hd
`define GLMC_REG_LPFM_HI    4'he

// Mode register fields
`define GLMC_MODE_LOCK_BIT  0
`define GLMC_MODE_SRC_BIT   1
`define GLMC_MODE_HOLD_BIT  2
`define GLMC_MODE_PORT_BIT  3
`define GLMC_MODE_RESET     8'h02

// HD clock register fields
`define GLMC_HD_TRI_BIT     3
`define GLMC_HD_RATE_LSB    4
`define GLMC_HD_RATE_148_35 2'h3
`define GLMC_HDCLK_RESET    8'h08

// Align enable sits at the top of the upper frame-pulse byte
`define GLMC_TOF_ALIGN_BIT  7

// Loop states
`define GLMC_LS_FREE        2'h0
`define GLMC_LS_TRACK       2'h1
`define GLMC_LS_LOR_FREE    2'h2
`define GLMC_LS_HOLD        2'h3

// Timing: clock period, VCXO period, reference timeout
`define GLMC_CLK_PERIOD_PS  25000
`define GLMC_VCXO_PERIOD_PS 37037
`define GLMC_VCXO_CYCLES    ((`GLMC_VCXO_PERIOD_PS + `GLMC_CLK_PERIOD_PS - 1) / `GLMC_CLK_PERIOD_PS)
`define GLMC_REF_TIMEOUT_NS 100000
`define GLMC_REF_TIMEOUT_CYCLES ((`GLMC_REF_TIMEOUT_NS * 1000) / `GLMC_CLK_PERIOD_PS)

`endif

// ==== hw/glmc_ref_monitor.v ====
// Purpose: Reference presence and loop lock flags
// Assumes: hsync_i and pll_locked_i synchronous to clk_i
// Notes:   Loss is flagged when no sync edge arrives within the timeout
`timescale 1ns/1ps
`default_nettype none
`include "glmc_defines.vh"

module glmc_ref_monitor #(
  parameter TIMEOUT_CYCLES = `GLMC_REF_TIMEOUT_CYCLES,
  parameter CNT_W          = 16
) (
  // Clock and reset
  input  wire clk_i,
  input  wire reset_i,
  // Reference side
  input  wire hsync_i,
  input  wire pll_locked_i,
  // Flags
  output reg  reference_loss_o,
  output reg  no_lock_o
);

  localparam [CNT_W-1:0] LIMIT = TIMEOUT_CYCLES[CNT_W-1:0];

  reg             hsync_q_r;
  reg [CNT_W-1:0] gap_cnt_r;
  wire            sync_edge = hsync_i & ~hsync_q_r;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hsync_q_r        <= 1'b0;
      gap_cnt_r        <= {CNT_W{1'b0}};
      reference_loss_o <= 1'b1;
      no_lock_o        <= 1'b1;
    end else begin
      hsync_q_r <= hsync_i;
      if (sync_edge) begin
        gap_cnt_r        <= {CNT_W{1'b0}};
        reference_loss_o <= 1'b0;
      end else if (gap_cnt_r >= LIMIT) begin
        reference_loss_o <= 1'b1;
      end else begin
        gap_cnt_r <= gap_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      // Lost reference reads as unlocked from the cycle after the loss flag rises
      no_lock_o <= ~pll_locked_i | (reference_loss_o & ~sync_edge);
    end
  end

endmodule

`default_nettype wire

// ==== sim/glmc_top_chk.sv ====
// Purpose: Concurrent checks on the genlock mode control ports
// Assumes: Loop outputs and register copies are registered alongside each other
// Notes:   Bound to every glmc_top instance
`timescale 1ns/1ps
`default_nettype none

module glmc_top_chk (
  // Clock, reset and serial port
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        port_enable_n_i,
  input wire logic        sda_oe_o,
  // Loop control
  input wire logic        frame_start_pulse_i,
  input wire logic [1:0]  loop_state_o,
  input wire logic        freerun_bias_switch_o,
  input wire logic        loop_filter_output_en_o,
  input wire logic        phase_detect_en_o,
  input wire logic        frame_align_o,
  input wire logic        reference_loss_o,
  // Clock configuration
  input wire logic [1:0]  hd_rate_select_o,
  input wire logic        hd_output_tristate_o,
  input wire logic        hd_counter_reset_o,
  input wire logic        output_align_enable_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  port_off_quiet_a: assert property (
    port_enable_n_i && $past(port_enable_n_i) |-> !sda_oe_o) else $error("ack while port off");
  bias_switch_a: assert property (
    freerun_bias_switch_o == !loop_state_o[0]) else $error("bias switch wrong for state");
  holdover_hiz_a: assert property (
    loop_filter_output_en_o == (loop_state_o != 2'h3)) else $error("filter drive wrong");
  track_only_a: assert property (
    phase_detect_en_o == (loop_state_o == 2'h1)) else $error("phase detector wrong");
  loss_fallback_a: assert property (
    $rose(reference_loss_o) && $past(loop_state_o) == 2'h1 |-> ##[0:2] loop_state_o[1])
    else $error("no fallback on reference loss");
  ref_return_a: assert property (
    $fell(reference_loss_o) && $past(loop_state_o[1]) |-> ##[0:2] loop_state_o == 2'h1)
    else $error("no relock on reference return");
  hd_reset_cond_a: assert property (
    hd_counter_reset_o |-> hd_rate_select_o == 2'h3 && !hd_output_tristate_o
      && output_align_enable_o) else $error("counter reset without setting");
  frame_align_a: assert property (
    frame_align_o |-> $past(frame_start_pulse_i) || $past(frame_start_pulse_i, 2))
    else $error("alignment without frame start");

  cover property (loop_state_o == 2'h3);
  cover property (frame_align_o);
  cover property ($rose(hd_counter_reset_o));
endmodule

bind glmc_top glmc_top_chk chk (
  .clk_i(clk_i), .reset_i(reset_i), .port_enable_n_i(port_enable_n_i), .sda_oe_o(sda_oe_o),
  .frame_start_pulse_i(frame_start_pulse_i), .loop_state_o(loop_state_o),
  .freerun_bias_switch_o(freerun_bias_switch_o), .phase_detect_en_o(phase_detect_en_o),
  .loop_filter_output_en_o(loop_filter_output_en_o), .frame_align_o(frame_align_o),
  .reference_loss_o(reference_loss_o), .hd_rate_select_o(hd_rate_select_o),
  .hd_output_tristate_o(hd_output_tristate_o), .hd_counter_reset_o(hd_counter_reset_o),
  .output_align_enable_o(output_align_enable_o)
);
`default_nettype wire

// ==== sim/glmc_i2c_host.sv ====
// Purpose: Two-wire bus host that programs the block
// Assumes: Data line resolved with a pull-up outside this model
// Notes:   Bus clock high phase spans four system clocks, low phase five
`timescale 1ns/1ps
`default_nettype none

module glmc_i2c_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Data moves only while the bus clock is low, so no false start or stop
  task automatic bit_slot(input logic b, output logic seen);
    sda_low_o <= ~b;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    seen = sda_i;
    scl_o <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic bus_start;
    sda_low_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic bus_stop;
    sda_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    bus_start();
    send_byte(8'hdc, k0);
    send_byte(a, k1);
    send_byte(d, k2);
    bus_stop();
    ok = k0 & k1 & k2;
  endtask

  // Single-byte read ends with a refusal so the device goes idle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2, s;
    bus_start();
    send_byte(8'hdc, k0);
    send_byte(a, k1);
    bus_start();
    send_byte(8'hdd, k2);
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(1'b1, s);
    bus_stop();
    ok = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

// ==== sim/test_genlock_mode_control.sv ====
// Purpose: Self-checking bench for the genlock mode control block
// Assumes: Host model drives the bus; reference sync is made here
// Notes:   Reference timeout shortened to 50 cycles to keep the run brief
`timescale 1ns/1ps
`default_nettype none

module test_genlock_mode_control;
  logic        clk_i = 1'b0, reset_i = 1'b1, port_enable_n_i = 1'b0, genlock_pin_i = 1'b0;
  logic        hsync_i = 1'b0, pll_locked_i = 1'b1, frame_start_pulse_i = 1'b0;
  logic        ref_run = 1'b0, ok;
  logic [7:0]  rd;
  int          cycles = 0, align_hits = 0, fail_count = 0, check_count = 0;
  wire         scl, sda_low, sda_o, sda_oe_o, bias_sw, lpf_en, pd_en, frame_align_o;
  wire         reference_loss_o, tri_o, cnt_rst, clk_valid, align_en, port_sel;
  wire [11:0]  tof_o;
  wire [1:0]   loop_state_o, rate_o;
  wire [15:0]  feedback_divider, lpfm_o;
  wire         sda_line = ~(sda_low | (sda_oe_o & ~sda_o));
  logic [15:0] boot_seq [0:6] = '{16'h0830, 16'h0401, 16'h0500, 16'h0901, 16'h0d01,
                                  16'h0e00, 16'h0a80};

  glmc_top #(.REF_TIMEOUT_CYCLES(50), .VCXO_CYCLES(2)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .port_enable_n_i(port_enable_n_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .genlock_pin_i(genlock_pin_i),
    .hsync_i(hsync_i), .pll_locked_i(pll_locked_i), .frame_start_pulse_i(frame_start_pulse_i),
    .loop_state_o(loop_state_o), .freerun_bias_switch_o(bias_sw),
    .loop_filter_output_en_o(lpf_en), .phase_detect_en_o(pd_en), .ref_port_select_o(port_sel),
    .frame_align_o(frame_align_o), .reference_loss_o(reference_loss_o), .no_lock_o(),
    .hd_rate_select_o(rate_o), .hd_output_tristate_o(tri_o), .hd_counter_reset_o(cnt_rst),
    .hd_clock_valid_o(clk_valid), .feedback_divider_o(feedback_divider), .frame_pulse_reset_value_o(tof_o),
    .reference_filter_mode_o(lpfm_o), .output_align_enable_o(align_en));
  glmc_i2c_host host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Sync period of 16 cycles stays well inside the shortened timeout
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    hsync_i <= ref_run & cycles[3];
    if (frame_align_o === 1'b1) align_hits <= align_hits + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic frame_pulse;
    frame_start_pulse_i <= 1'b1;
    @(posedge clk_i);
    frame_start_pulse_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(loop_state_o, 16'h0000);
    check(bias_sw, 16'h0001);
    port_enable_n_i <= 1'b1;
    host.write_reg(8'h00, 8'h03, ok);
    check(ok, 16'h0000);
    check(loop_state_o, 16'h0000);
    port_enable_n_i <= 1'b0;
    host.bus_start();
    host.send_byte(8'hde, ok);
    host.bus_stop();
    check(ok, 16'h0000);
    foreach (boot_seq[i]) begin
      host.write_reg(boot_seq[i][15:8], boot_seq[i][7:0], ok);
      check(ok, 16'h0001);
    end
    check(rate_o, 16'h0003);
    check(tri_o, 16'h0000);
    check(feedback_divider, 16'h0001);
    check(tof_o, 16'h0001);
    check(lpfm_o, 16'h0001);
    check(align_en, 16'h0001);
    check(cnt_rst, 16'h0001);
    check(clk_valid, 16'h0000);
    repeat (4) @(posedge clk_i);
    host.write_reg(8'h0a, 8'h00, ok);
    check(cnt_rst, 16'h0000);
    check(clk_valid, 16'h0001);
    host.read_reg(8'h08, rd, ok);
    check(rd, 16'h0030);
    host.read_reg(8'h01, rd, ok);
    check(rd, 16'h000c);
    ref_run <= 1'b1;
    host.write_reg(8'h00, 8'h03, ok);
    check(loop_state_o, 16'h0001);
    check(pd_en, 16'h0001);
    check(bias_sw, 16'h0000);
    check(reference_loss_o, 16'h0000);
    frame_pulse();
    check(16'(align_hits), 16'h0000);
    host.write_reg(8'h0a, 8'h80, ok);
    frame_pulse();
    frame_pulse();
    check(16'(align_hits), 16'h0002);
    host.write_reg(8'h0a, 8'h00, ok);
    host.write_reg(8'h08, 8'h38, ok); // HD output tristated
    check(clk_valid, 16'h0000);
    foreach (boot_seq[j]) host.write_reg(boot_seq[j][15:8], boot_seq[j][7:0], ok);
    repeat (4) @(posedge clk_i);
    host.write_reg(8'h0a, 8'h00, ok);
    check(clk_valid, 16'h0001);
    for (int h = 0; h < 2; h++) begin
      host.write_reg(8'h00, {5'h00, h[0], 2'h3}, ok);
      ref_run <= 1'b0;
      repeat (90) @(posedge clk_i);
      check(loop_state_o, {14'h0000, 1'b1, h[0]});
      check(lpf_en, {15'h0000, ~h[0]});
      ref_run <= 1'b1;
      repeat (30) @(posedge clk_i);
      check(loop_state_o, 16'h0001);
    end
    host.write_reg(8'h00, 8'h02, ok);
    check(loop_state_o, 16'h0000);
    ref_run <= 1'b0;
    repeat (90) @(posedge clk_i);
    check(loop_state_o, 16'h0000);
    host.write_reg(8'h00, 8'h00, ok);
    genlock_pin_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(loop_state_o, 16'h0002);
    genlock_pin_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(loop_state_o, 16'h0000);
    host.write_reg(8'h00, 8'h08, ok);
    check(port_sel, 16'h0001);
    tally_and_finish();
  end
endmodule
`default_nettype wire
